// *** bench/gpio_aux_pin_function_mux_tb_top.sv ***
// self-checking bench for the pin function multiplexer
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin \
	tests_run++; \
	if ((a) !== (b)) begin \
		errors++; \
		$display("FAIL t=%0t got %h exp %h", $time, (a), (b)); \
	end \
end
`define WAIT_UNTIL(c) begin \
	wcnt = 0; \
	while ((c) !== 1'b1) begin \
		@(negedge clk); \
		wcnt++; \
		if (wcnt > 5000) begin \
			errors++; \
			results(); \
		end \
	end \
end
module gpio_aux_pin_function_mux_tb_top
	import pin_mux_pkg::*;
;
	localparam int SEC = 400;
	localparam int HI = 20;
	int errors = 0;
	int tests_run = 0;
	int wcnt = 0;
	int n_good = 0;
	int n_bad = 0;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	pin_fn_t fn1 = FN_PPS_OUT;
	pin_fn_t fn2 = FN_OFF;
	pin_fn_t fnt = FN_PPS_OUT;
	pin_fn_t fnr = FN_OFF;
	logic [13:0] gdiv = 14'h0050;
	logic [13:0] adiv = 14'h000a;
	logic tvalid = 1'b0;
	logic tcorr = 1'b0;
	logic [2:0] fix = 3'h0;
	logic [31:0] scale = 32'h0;
	logic [15:0] nper = 16'h0005;
	logic [7:0] txd = 8'h00;
	logic txv = 1'b0;
	logic g1_o, g1_oe, g2_o, g2_oe, atx, atx_oe, txrdy, rxv, ngood, nbad, ntick;
	logic pps, tinit, sok, stat, far_a, far_b, far_r;
	logic [7:0] rxd;
	logic [7:0] last_rx = 8'h00;
	logic [31:0] odo, pit;
	pin_fn_t rxfn;
	pin_fn_t last_fn = FN_OFF;
	wire logic g1_pin;
	wire logic g2_pin;
	// pin level: the block wins while it drives, else the far side
	assign g1_pin = g1_oe ? g1_o : far_a;
	assign g2_pin = g2_oe ? g2_o : far_b;
	always #25 clk = ~clk;
	gpio_aux_pin_function_mux #(.PPS_SEC_CYC(25'h190), .PPS_HIGH_CYC(25'h014),
		.PPS_START_CYC(25'h028), .CYC_PER_MS(16'h0002)) dut (
		.i_clk(clk), .i_rst_n(rst_n), .i_gpio1_fn(fn1), .i_gpio2_fn(fn2),
		.i_aux_tx_fn(fnt), .i_aux_rx_fn(fnr), .i_gpio1(g1_pin), .o_gpio1(g1_o),
		.o_gpio1_oe(g1_oe), .i_gpio2(g2_pin), .o_gpio2(g2_o), .o_gpio2_oe(g2_oe),
		.o_aux_tx(atx), .o_aux_tx_oe(atx_oe), .i_aux_rx(far_r), .i_gpio_div(gdiv),
		.i_aux_div(adiv), .i_time_valid(tvalid), .i_time_corr(tcorr), .i_fix_type(fix),
		.i_odo_scale(scale), .i_nmea_period_ms(nper), .i_tx_data(txd), .i_tx_valid(txv),
		.o_tx_ready(txrdy), .o_rx_data(rxd), .o_rx_valid(rxv), .o_rx_fn(rxfn),
		.o_nmea_good(ngood), .o_nmea_bad(nbad), .o_nmea_tick(ntick), .o_pps(pps),
		.o_time_init(tinit), .o_odo_scale_ok(sok), .o_odo_count(odo),
		.o_stationary(stat), .o_pitot_freq(pit));
	pin_far_side far (.i_clk(clk), .i_tx_line(g1_pin), .o_line_a(far_a),
		.o_line_b(far_b), .o_line_r(far_r));
	// tally verdict pulses and keep the last received byte
	always @(posedge clk) begin
		if (ngood === 1'b1) n_good++;
		if (nbad === 1'b1) n_bad++;
		if (rxv === 1'b1) begin
			last_rx <= rxd;
			last_fn <= rxfn;
		end
	end
	task automatic results();
		if (errors == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	function automatic logic [7:0] hexc(input logic [3:0] n);
		return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
	endfunction
	// start delay, width, period and edge sense of the second pulse
	task automatic t_pps();
		`WAIT_UNTIL(pps)
		`CHK(wcnt inside {[38:42]}, 1'b1)
		@(negedge clk);
		`CHK({g1_o, g1_oe, atx, atx_oe}, 4'hd)
		`WAIT_UNTIL(pps === 1'b0)
		`CHK(wcnt, HI - 1)
		`WAIT_UNTIL(pps)
		`CHK(wcnt, SEC - HI)
		tvalid = 1'b1;
		repeat (2) @(negedge clk);
		`CHK(tinit, 1'b1)
	endtask
	// a correction mid second restarts the pulse at once
	task automatic t_corr();
		repeat (100) @(negedge clk);
		tcorr = 1'b1;
		@(negedge clk);
		tcorr = 1'b0;
		`WAIT_UNTIL(pps)
		`CHK(wcnt < 3, 1'b1)
	endtask
	// fix output over every fix code
	task automatic t_fix();
		fn2 = FN_FIX_OUT;
		repeat (8) @(negedge clk);
		for (int f = 0; f < 8; f++) begin
			fix = 3'(f);
			repeat (3) @(negedge clk);
			`CHK({g2_oe, g2_o}, {1'b1, f >= 2})
		end
	endtask
	// tristate gap on change, illegal choice stays off
	task automatic t_switch();
		fn2 = FN_PPS_OUT;
		repeat (3) @(negedge clk);
		`CHK(g2_oe, 1'b0)
		repeat (5) @(negedge clk);
		`CHK(g2_oe, 1'b1)
		fn2 = FN_NMEA_OUT;
		repeat (10) @(negedge clk);
		`CHK(g2_oe, 1'b0)
	endtask
	// odometer count and scale limits
	task automatic t_odo();
		logic [31:0] c0;
		logic [31:0] sv [4] = '{32'h0, 32'h1, 32'h00418937, 32'h00418938};
		logic sk [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
		fn1 = FN_ODO_IN;
		repeat (8) @(negedge clk);
		c0 = odo;
		far.pulses(0, 25);
		repeat (4) @(negedge clk);
		`CHK(odo, c0 + 32'h19)
		foreach (sv[i]) begin
			scale = sv[i];
			repeat (3) @(negedge clk);
			`CHK(sok, sk[i])
		end
	endtask
	task automatic t_zvel();
		fnr = FN_ZVEL_IN;
		repeat (8) @(negedge clk);
		far.put(2, 1'b0, 6);
		`CHK(stat, 1'b0)
		far.put(2, 1'b1, 6);
		`CHK(stat, 1'b1)
	endtask
	// 34 cycle pulses give 11 or 12 edges per 400 cycle second
	task automatic t_pitot();
		far.put(1, 1'b0, 2);
		fn2 = FN_PITOT_IN;
		repeat (8) @(negedge clk);
		far.pulses(1, 30);
		`CHK(pit inside {[11:12]}, 1'b1)
	endtask
	// one sentence, checksum bits flipped by flip
	task automatic sentence(input string s, input logic [7:0] flip);
		logic [7:0] ck;
		ck = flip;
		far.uart_send(2, CH_DOLLAR, 10);
		for (int i = 0; i < 5; i++) begin
			ck ^= s[i];
			far.uart_send(2, s[i], 10);
		end
		far.uart_send(2, CH_STAR, 10);
		far.uart_send(2, hexc(ck[7:4]), 10);
		far.uart_send(2, hexc(ck[3:0]), 10);
		repeat (20) @(negedge clk);
	endtask
	task automatic t_nmea_in();
		int g;
		string ty [17] = '{"GPGGA", "GNGGA", "GPGLL", "GNGLL", "GPRMC", "GNRMC",
			"GPVTG", "GNVTG", "GPHDT", "GNHDT", "HEHDT", "GPGSV", "GNGSV", "GPGSA",
			"GNGSA", "GPZDA", "GNZDA"};
		far.put(2, 1'b1, 2);
		fnr = FN_NMEA_IN;
		repeat (8) @(negedge clk);
		foreach (ty[i]) begin
			g = n_good;
			sentence(ty[i], 8'h00);
			`CHK(n_good, g + 1)
		end
		g = n_bad;
		sentence("GPGGA", 8'h01);
		`CHK(n_bad, g + 1)
		`CHK(last_fn, FN_NMEA_IN)
	endtask
	// aiding byte on gpio2 at the fastest clamp edge of the gpio range
	task automatic t_pkt();
		fnr = FN_OFF;
		far.put(1, 1'b1, 2);
		fn2 = FN_PKT_IN;
		repeat (8) @(negedge clk);
		far.uart_send(1, 8'ha5, 80);
		repeat (10) @(negedge clk);
		`CHK(last_rx, 8'ha5)
		`CHK(last_fn, FN_PKT_IN)
		// then one byte for each binary receiver function
		fn2 = FN_POSLOG_IN;
		repeat (8) @(negedge clk);
		far.uart_send(1, 8'h5a, 80);
		repeat (10) @(negedge clk);
		`CHK({last_fn, last_rx}, {FN_POSLOG_IN, 8'h5a})
		fn2 = FN_POSMSG_IN;
		repeat (8) @(negedge clk);
		far.uart_send(1, 8'hc3, 80);
		repeat (10) @(negedge clk);
		`CHK({last_fn, last_rx}, {FN_POSMSG_IN, 8'hc3})
	endtask
	// output tick floor and one byte sent with a too fast divisor
	task automatic t_nmea_out();
		logic [7:0] rb;
		logic ok;
		far.put(0, 1'b1, 1);
		fn1 = FN_NMEA_OUT;
		`CHK(txrdy, 1'b0)
		repeat (8) @(negedge clk);
		`WAIT_UNTIL(ntick)
		@(negedge clk);
		`WAIT_UNTIL(ntick)
		`CHK(wcnt + 1, int'(NMEA_MIN_PERIOD_MS) * 2)
		gdiv = 14'h000a;
		fork
			far.uart_recv(80, rb, ok);
			begin
				`WAIT_UNTIL(txrdy)
				txd = 8'h3c;
				txv = 1'b1;
				@(negedge clk);
				txv = 1'b0;
				`CHK(txrdy, 1'b0)
			end
		join
		`CHK({ok, rb}, 9'h13c)
	endtask
	initial begin
		repeat (10) @(negedge clk);
		`CHK({g1_oe, g2_oe, atx_oe, pps, txrdy, rxv}, 6'h00)
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		t_pps();
		t_corr();
		t_fix();
		t_switch();
		t_odo();
		t_zvel();
		t_pitot();
		t_nmea_in();
		t_pkt();
		t_nmea_out();
		results();
	end
endmodule // gpio_aux_pin_function_mux_tb_top
`default_nettype wire

// *** bench/pin_far_side.sv ***
// far side model: sensors and serial peers wired to the pins
`timescale 1ns/1ns
`default_nettype none
module pin_far_side (
	input wire logic i_clk,
	input wire logic i_tx_line,
	output logic o_line_a,
	output logic o_line_b,
	output logic o_line_r
);
	// sensor lines rest low, serial lines rest high
	initial begin
		o_line_a = 1'b0;
		o_line_b = 1'b1;
		o_line_r = 1'b1;
	end
	// drive a line (0 gpio1, 1 gpio2, 2 aux rx) for n cycles
	task automatic put(input int sel, input logic v, input int n);
		case (sel)
			0: o_line_a = v;
			1: o_line_b = v;
			default: o_line_r = v;
		endcase
		repeat (n) @(negedge i_clk);
	endtask
	// one frame: start, eight data bits lsb first, stop
	task automatic uart_send(input int sel, input logic [7:0] b, input int div);
		put(sel, 1'b0, div);
		for (int i = 0; i < 8; i++) begin
			put(sel, b[i], div);
		end
		put(sel, 1'b1, div);
	endtask
	// pulses near 588 kHz, line held low between them
	task automatic pulses(input int sel, input int n);
		for (int i = 0; i < n; i++) begin
			put(sel, 1'b1, 17);
			put(sel, 1'b0, 17);
		end
	endtask
	// sample a frame at mid bit, ok holds the start and stop levels
	task automatic uart_recv(input int div, output logic [7:0] b, output logic ok);
		int k;
		k = 0;
		b = 8'h00;
		while (i_tx_line !== 1'b0 && k < 4000) begin
			@(negedge i_clk);
			k++;
		end
		repeat (div / 2) @(negedge i_clk);
		ok = (k < 4000) && (i_tx_line === 1'b0);
		for (int i = 0; i < 8; i++) begin
			repeat (div) @(negedge i_clk);
			b[i] = i_tx_line;
		end
		repeat (div) @(negedge i_clk);
		ok = ok && (i_tx_line === 1'b1);
	endtask
endmodule // pin_far_side
`default_nettype wire

// *** logic/gpio_aux_pin_function_mux.sv ***
// pin function multiplexer for two general pins and the auxiliary serial lines
// Summary of operation
// - serial receive only on gpio2 or aux rx, transmit only gpio1 or aux tx
// - pulse output high for 50 ms at the start of every second
// - second pulses begin about 100 ms after reset release
// - second pulses run whether or not time is valid
// - a time correction restarts the second, giving a possibly short interval
// - time initialised flag reported to the outside
// - aux tx marks the second with a falling edge, gpio with rising
// - fix output low for no fix or a 2D fix
// - fix output high for 3D, SBAS, differential or RTK fix
// - odometer counts low to high edges of a normally low input
// - odometer handles 600 kHz and scale up to 4294967 pulses per metre
// - zero velocity input high means stationary, low means moving
// - nmea sentences with an invalid checksum are flagged for discard
// - nmea accepts GP/GN GGA GLL RMC VTG HDT GSV GSA ZDA and HEHDT
// - nmea output tick at configurable rate up to 50 Hz
// - packet input is for peripherals and aiding only, not commands
// - serial frames are 1 start, 8 data, 1 stop, no parity
// - gpio serial 2400 to 250 k baud, aux serial 2400 to 2 M baud
`timescale 1ns/1ns
`default_nettype none
module gpio_aux_pin_function_mux
	import pin_mux_pkg::*;
#(
	parameter logic [24:0] PPS_SEC_CYC = 25'(PPS_SEC_DEF),
	parameter logic [24:0] PPS_HIGH_CYC = 25'(PPS_HIGH_DEF),
	parameter logic [24:0] PPS_START_CYC = 25'(PPS_START_DEF),
	parameter logic [15:0] CYC_PER_MS = 16'(CYC_PER_MS_DEF)
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire pin_fn_t i_gpio1_fn,
	input wire pin_fn_t i_gpio2_fn,
	input wire pin_fn_t i_aux_tx_fn,
	input wire pin_fn_t i_aux_rx_fn,
	input wire logic i_gpio1,
	output logic o_gpio1,
	output logic o_gpio1_oe,
	input wire logic i_gpio2,
	output logic o_gpio2,
	output logic o_gpio2_oe,
	output logic o_aux_tx,
	output logic o_aux_tx_oe,
	input wire logic i_aux_rx,
	input wire logic [13:0] i_gpio_div,
	input wire logic [13:0] i_aux_div,
	input wire logic i_time_valid,
	input wire logic i_time_corr,
	input wire logic [2:0] i_fix_type,
	input wire logic [31:0] i_odo_scale,
	input wire logic [15:0] i_nmea_period_ms,
	input wire logic [7:0] i_tx_data,
	input wire logic i_tx_valid,
	output logic o_tx_ready,
	output logic [7:0] o_rx_data,
	output logic o_rx_valid,
	output var pin_fn_t o_rx_fn,
	output logic o_nmea_good,
	output logic o_nmea_bad,
	output logic o_nmea_tick,
	output logic o_pps,
	output logic o_time_init,
	output logic o_odo_scale_ok,
	output logic [31:0] o_odo_count,
	output logic o_stationary,
	output logic [31:0] o_pitot_freq
);
	// active level of an input function, lowest pin wins
	function automatic logic pick(input pin_fn_t f, input pin_fn_t [3:0] a, input logic [3:0] v);
		pick = 1'b0;
		for (int p = 3; p >= 0; p--) begin
			if (a[p] == f && p != 2) pick = v[p];
		end
	endfunction

	function automatic logic [13:0] clamp_div(input logic [13:0] d, input logic [13:0] lo);
		clamp_div = (d < lo) ? lo : ((d > DIV_MAX) ? DIV_MAX : d);
	endfunction

	function automatic logic [4:0] hexval(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39) hexval = {1'b1, c[3:0]};
		else if (c >= 8'h41 && c <= 8'h46) hexval = {1'b1, 4'(c[3:0] + 4'h9)};
		else hexval = 5'h00;
	endfunction

	function automatic logic nmea_type_ok(input logic [39:0] h);
		logic [23:0] t;
		t = h[23:0];
		nmea_type_ok = (h == "HEHDT") || ((h[39:24] == "GP" || h[39:24] == "GN")
			&& (t == "GGA" || t == "GLL" || t == "RMC" || t == "VTG" || t == "HDT"
			|| t == "GSV" || t == "GSA" || t == "ZDA"));
	endfunction

	// input synchronisers, first stage read only by the second
	logic [3:0] pin_in, meta_q, sync_q, prev_q;
	assign pin_in = {i_aux_rx, 1'b0, i_gpio2, i_gpio1};
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_q <= 4'h0;
			sync_q <= 4'h0;
			prev_q <= 4'h0;
		end else begin
			meta_q <= pin_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// function selection with a tristate settling gap on each change
	pin_fn_t [3:0] fn_in, req, act_d, act_q;
	logic [3:0][2:0] sw_d, sw_q;
	assign fn_in = '{i_aux_rx_fn, i_aux_tx_fn, i_gpio2_fn, i_gpio1_fn};
	always_comb begin
		act_d = act_q;
		sw_d = sw_q;
		for (int p = 0; p < 4; p++) begin
			req[p] = fn_legal(2'(p), fn_in[p]) ? fn_in[p] : FN_OFF;
			if (sw_q[p] != 3'h0) begin
				sw_d[p] = sw_q[p] - 3'h1;
				if (sw_q[p] == 3'h1) act_d[p] = req[p];
			end else if (req[p] != act_q[p]) begin
				act_d[p] = FN_OFF;
				sw_d[p] = SWITCH_CYC;
			end
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			act_q <= '{FN_OFF, FN_OFF, FN_OFF, FN_OFF};
			sw_q <= '0;
		end else begin
			act_q <= act_d;
			sw_q <= sw_d;
		end
	end

	// second pulse timer, starts part way so the first pulse lands late
	logic [24:0] pps_cnt_d, pps_cnt_q;
	logic pps_d, pps_q, sec_tick;
	always_comb begin
		sec_tick = (pps_cnt_q == PPS_SEC_CYC - 25'h1) || i_time_corr;
		pps_cnt_d = sec_tick ? 25'h0 : pps_cnt_q + 25'h1;
		pps_d = pps_cnt_d < PPS_HIGH_CYC;
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pps_cnt_q <= PPS_SEC_CYC - PPS_START_CYC;
			pps_q <= 1'b0;
		end else begin
			pps_cnt_q <= pps_cnt_d;
			pps_q <= pps_d;
		end
	end
	assign o_pps = pps_q;

	// status and measured inputs
	logic odo_edge, pitot_edge, fix_d, fix_q;
	logic [31:0] odo_d, pitot_cnt_d, pitot_cnt_q, pitot_freq_d;
	always_comb begin
		odo_edge = pick(FN_ODO_IN, act_q, sync_q) && !pick(FN_ODO_IN, act_q, prev_q);
		pitot_edge = pick(FN_PITOT_IN, act_q, sync_q) && !pick(FN_PITOT_IN, act_q, prev_q);
		odo_d = o_odo_count + {31'h0, odo_edge};
		pitot_cnt_d = sec_tick ? {31'h0, pitot_edge} : pitot_cnt_q + {31'h0, pitot_edge};
		pitot_freq_d = sec_tick ? pitot_cnt_q : o_pitot_freq;
		fix_d = i_fix_type >= FIX_3D;
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_odo_count <= 32'h0;
			pitot_cnt_q <= 32'h0;
			o_pitot_freq <= 32'h0;
			fix_q <= 1'b0;
			o_stationary <= 1'b0;
			o_time_init <= 1'b0;
			o_odo_scale_ok <= 1'b0;
		end else begin
			o_odo_count <= odo_d;
			pitot_cnt_q <= pitot_cnt_d;
			o_pitot_freq <= pitot_freq_d;
			fix_q <= fix_d;
			o_stationary <= pick(FN_ZVEL_IN, act_q, sync_q);
			o_time_init <= i_time_valid;
			o_odo_scale_ok <= (i_odo_scale != 32'h0) && (i_odo_scale <= ODO_MAX_SCALE);
		end
	end

	// nmea output pacing tick, period floored at the 50 Hz limit
	logic [31:0] tick_cnt_d, tick_cnt_q, tick_per;
	logic tick_d, tx_on;
	always_comb begin
		tx_on = (act_q[PIN_GPIO1] == FN_NMEA_OUT) || (act_q[PIN_AUX_TX] == FN_NMEA_OUT);
		tick_per = 32'((i_nmea_period_ms < NMEA_MIN_PERIOD_MS ? NMEA_MIN_PERIOD_MS
			: i_nmea_period_ms) * CYC_PER_MS);
		tick_d = tx_on && (tick_cnt_q + 32'h1 >= tick_per);
		tick_cnt_d = (!tx_on || tick_d) ? 32'h0 : tick_cnt_q + 32'h1;
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tick_cnt_q <= 32'h0;
			o_nmea_tick <= 1'b0;
		end else begin
			tick_cnt_q <= tick_cnt_d;
			o_nmea_tick <= tick_d;
		end
	end

	// serial transmitter, 8N1
	logic tx_busy_d, tx_busy_q;
	logic [3:0] tx_bit_d, tx_bit_q;
	logic [13:0] tx_baud_d, tx_baud_q, tx_div;
	logic [9:0] tx_sh_d, tx_sh_q;
	assign o_tx_ready = tx_on && !tx_busy_q;
	always_comb begin
		tx_div = (act_q[PIN_GPIO1] == FN_NMEA_OUT) ? clamp_div(i_gpio_div, GPIO_DIV_MIN)
			: clamp_div(i_aux_div, AUX_DIV_MIN);
		tx_busy_d = tx_busy_q;
		tx_bit_d = tx_bit_q;
		tx_baud_d = tx_baud_q;
		tx_sh_d = tx_sh_q;
		if (!tx_busy_q) begin
			if (i_tx_valid && o_tx_ready) begin
				tx_sh_d = {1'b1, i_tx_data, 1'b0};
				tx_busy_d = 1'b1;
				tx_bit_d = 4'h0;
				tx_baud_d = tx_div - 14'h1;
			end
		end else if (tx_baud_q != 14'h0) begin
			tx_baud_d = tx_baud_q - 14'h1;
		end else begin
			tx_baud_d = tx_div - 14'h1;
			tx_sh_d = {1'b1, tx_sh_q[9:1]};
			tx_bit_d = tx_bit_q + 4'h1;
			if (tx_bit_q == UART_LAST_BIT) tx_busy_d = 1'b0;
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tx_busy_q <= 1'b0;
			tx_bit_q <= 4'h0;
			tx_baud_q <= 14'h0;
			tx_sh_q <= 10'h3ff;
		end else begin
			tx_busy_q <= tx_busy_d;
			tx_bit_q <= tx_bit_d;
			tx_baud_q <= tx_baud_d;
			tx_sh_q <= tx_sh_d;
		end
	end

	// pin drivers, registered
	logic [3:0] out_d, out_q, oe_d, oe_q;
	always_comb begin
		for (int p = 0; p < 4; p++) begin
			oe_d[p] = (act_q[p] == FN_PPS_OUT) || (act_q[p] == FN_FIX_OUT)
				|| (act_q[p] == FN_NMEA_OUT);
			case (act_q[p])
				FN_PPS_OUT: out_d[p] = (p == 2) ? !pps_q : pps_q;
				FN_FIX_OUT: out_d[p] = fix_q;
				FN_NMEA_OUT: out_d[p] = tx_busy_q ? tx_sh_q[0] : 1'b1;
				default: out_d[p] = 1'b0;
			endcase
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			out_q <= 4'h0;
			oe_q <= 4'h0;
		end else begin
			out_q <= out_d;
			oe_q <= oe_d;
		end
	end
	assign o_gpio1 = out_q[0];
	assign o_gpio1_oe = oe_q[0];
	assign o_gpio2 = out_q[1];
	assign o_gpio2_oe = oe_q[1];
	assign o_aux_tx = out_q[2];
	assign o_aux_tx_oe = oe_q[2];

	// serial receiver, aux rx preferred over gpio2
	logic rx_on, rx_line, rx_busy_d, rx_busy_q, rx_vld_d;
	logic [3:0] rx_bit_d, rx_bit_q;
	logic [13:0] rx_baud_d, rx_baud_q, rx_div;
	logic [7:0] rx_sh_d, rx_sh_q;
	pin_fn_t rx_fn;
	always_comb begin
		rx_fn = is_rx_fn(act_q[PIN_AUX_RX]) ? act_q[PIN_AUX_RX] : act_q[PIN_GPIO2];
		rx_on = is_rx_fn(rx_fn);
		rx_line = is_rx_fn(act_q[PIN_AUX_RX]) ? sync_q[3] : sync_q[1];
		rx_div = is_rx_fn(act_q[PIN_AUX_RX]) ? clamp_div(i_aux_div, AUX_DIV_MIN)
			: clamp_div(i_gpio_div, GPIO_DIV_MIN);
		rx_busy_d = rx_busy_q;
		rx_bit_d = rx_bit_q;
		rx_baud_d = rx_baud_q;
		rx_sh_d = rx_sh_q;
		rx_vld_d = 1'b0;
		if (!rx_busy_q) begin
			if (rx_on && !rx_line) begin
				rx_busy_d = 1'b1;
				rx_bit_d = 4'h0;
				rx_baud_d = {1'b0, rx_div[13:1]};
			end
		end else if (rx_baud_q != 14'h0) begin
			rx_baud_d = rx_baud_q - 14'h1;
		end else begin
			rx_baud_d = rx_div - 14'h1;
			rx_bit_d = rx_bit_q + 4'h1;
			if (rx_bit_q == 4'h0 && rx_line) rx_busy_d = 1'b0;
			else if (rx_bit_q == UART_LAST_BIT) begin
				rx_busy_d = 1'b0;
				rx_vld_d = rx_line;
			end else if (rx_bit_q != 4'h0) rx_sh_d = {rx_line, rx_sh_q[7:1]};
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rx_busy_q <= 1'b0;
			rx_bit_q <= 4'h0;
			rx_baud_q <= 14'h0;
			rx_sh_q <= 8'h00;
			o_rx_valid <= 1'b0;
			o_rx_data <= 8'h00;
			o_rx_fn <= FN_OFF;
		end else begin
			rx_busy_q <= rx_busy_d;
			rx_bit_q <= rx_bit_d;
			rx_baud_q <= rx_baud_d;
			rx_sh_q <= rx_sh_d;
			o_rx_valid <= rx_vld_d;
			if (rx_vld_d) o_rx_data <= rx_sh_q;
			if (rx_vld_d) o_rx_fn <= rx_fn;
		end
	end

	// nmea sentence checker on received bytes
	nmea_st_t nm_d, nm_q;
	logic [7:0] ck_d, ck_q;
	logic [39:0] hdr_d, hdr_q;
	logic [2:0] hn_d, hn_q;
	logic [3:0] hi_d, hi_q;
	logic good_d, bad_d, nm_byte;
	logic [4:0] hv;
	always_comb begin
		nm_d = nm_q;
		ck_d = ck_q;
		hdr_d = hdr_q;
		hn_d = hn_q;
		hi_d = hi_q;
		good_d = 1'b0;
		bad_d = 1'b0;
		nm_byte = o_rx_valid && o_rx_fn == FN_NMEA_IN;
		hv = hexval(o_rx_data);
		if (nm_byte && o_rx_data == CH_DOLLAR) begin
			nm_d = NM_BODY;
			ck_d = 8'h00;
			hn_d = 3'h0;
		end else if (nm_byte) begin
			case (nm_q)
				NM_BODY: begin
					if (o_rx_data == CH_STAR) nm_d = NM_CK_HI;
					else begin
						ck_d = ck_q ^ o_rx_data;
						if (hn_q < NMEA_HDR_LEN) begin
							hdr_d = {hdr_q[31:0], o_rx_data};
							hn_d = hn_q + 3'h1;
						end
					end
				end
				NM_CK_HI: begin
					hi_d = hv[3:0];
					nm_d = hv[4] ? NM_CK_LO : NM_IDLE;
					bad_d = !hv[4];
				end
				NM_CK_LO: begin
					nm_d = NM_IDLE;
					good_d = hv[4] && {hi_q, hv[3:0]} == ck_q && hn_q == NMEA_HDR_LEN
						&& nmea_type_ok(hdr_q);
					bad_d = !good_d;
				end
				default: nm_d = NM_IDLE;
			endcase
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			nm_q <= NM_IDLE;
			ck_q <= 8'h00;
			hdr_q <= 40'h0;
			hn_q <= 3'h0;
			hi_q <= 4'h0;
			o_nmea_good <= 1'b0;
			o_nmea_bad <= 1'b0;
		end else begin
			nm_q <= nm_d;
			ck_q <= ck_d;
			hdr_q <= hdr_d;
			hn_q <= hn_d;
			hi_q <= hi_d;
			o_nmea_good <= good_d;
			o_nmea_bad <= bad_d;
		end
	end

	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_pps_end;
		$fell(pps_q);
	endsequence
	sequence s_fn_change(int p);
		sw_q[p] == 3'h0 && req[p] != act_q[p];
	endsequence
	a_rx_pin_legal: assert property (!is_rx_fn(act_q[0]) && !is_rx_fn(act_q[2]))
		else $error("serial receive on a transmit pin");
	a_tx_pin_legal: assert property (act_q[1] != FN_NMEA_OUT && act_q[3] != FN_NMEA_OUT)
		else $error("serial transmit on a receive pin");
	a_pps_width: assert property (s_pps_end |-> $past(pps_cnt_q) == PPS_HIGH_CYC - 25'h1)
		else $error("second pulse width wrong");
	a_pps_edges: assert property (act_q[2] == FN_PPS_OUT && $rose(pps_q) |=> $fell(o_aux_tx))
		else $error("aux second pulse not a falling edge");
	a_fix_level: assert property (act_q[1] == FN_FIX_OUT && $stable(act_q[1])
		|-> ##1 o_gpio2 == $past(fix_q) && o_gpio2_oe)
		else $error("fix output level wrong");
	a_switch_tristate: assert property (s_fn_change(0) |=> ##1 !o_gpio1_oe [*3])
		else $error("pin driven during function change");
	a_odo_count: assert property (odo_edge |=> o_odo_count == $past(o_odo_count) + 32'h1)
		else $error("odometer edge not counted");
	a_zvel_level: assert property (act_q[3] == FN_ZVEL_IN && act_q[0] != FN_ZVEL_IN
		&& act_q[1] != FN_ZVEL_IN |=> o_stationary == $past(sync_q[3]))
		else $error("stationary flag wrong");
	a_nmea_verdict: assert property (!(o_nmea_good && o_nmea_bad))
		else $error("nmea verdict both good and bad");
	a_pps_restart: assert property (i_time_corr |=> pps_cnt_q == 25'h0 ##1 pps_q)
		else $error("time correction did not restart second");
endmodule // gpio_aux_pin_function_mux
`default_nettype wire

// *** logic/pin_mux_pkg.sv ***
// constants, types and helpers shared by the pin function multiplexer
package pin_mux_pkg;
	typedef enum logic [3:0] {
		FN_OFF = 4'h0, FN_PPS_OUT = 4'h1, FN_FIX_OUT = 4'h2, FN_ODO_IN = 4'h3,
		FN_ZVEL_IN = 4'h4, FN_PITOT_IN = 4'h5, FN_NMEA_IN = 4'h6, FN_NMEA_OUT = 4'h7,
		FN_POSLOG_IN = 4'h8, FN_POSMSG_IN = 4'h9, FN_PKT_IN = 4'ha
	} pin_fn_t;
	typedef enum logic [1:0] {
		NM_IDLE = 2'b00, NM_BODY = 2'b01, NM_CK_HI = 2'b11, NM_CK_LO = 2'b10
	} nmea_st_t;
	localparam logic [1:0] PIN_GPIO1 = 2'h0;
	localparam logic [1:0] PIN_GPIO2 = 2'h1;
	localparam logic [1:0] PIN_AUX_TX = 2'h2;
	localparam logic [1:0] PIN_AUX_RX = 2'h3;
	localparam int CLK_HZ = 20_000_000;
	localparam int CYC_PER_MS_DEF = CLK_HZ / 1000;
	localparam int PPS_PERIOD_MS = 1000;
	localparam int PPS_HIGH_MS = 50;
	localparam int PPS_START_MS = 100;
	localparam int PPS_SEC_DEF = PPS_PERIOD_MS * CYC_PER_MS_DEF;
	localparam int PPS_HIGH_DEF = PPS_HIGH_MS * CYC_PER_MS_DEF;
	localparam int PPS_START_DEF = PPS_START_MS * CYC_PER_MS_DEF;
	localparam logic [15:0] NMEA_MIN_PERIOD_MS = 16'h0014; // 50 Hz ceiling
	localparam int GPIO_BAUD_MAX = 250_000;
	localparam int AUX_BAUD_MAX = 2_000_000;
	localparam int BAUD_MIN = 2400;
	localparam logic [13:0] GPIO_DIV_MIN = 14'((CLK_HZ + GPIO_BAUD_MAX - 1) / GPIO_BAUD_MAX);
	localparam logic [13:0] AUX_DIV_MIN = 14'((CLK_HZ + AUX_BAUD_MAX - 1) / AUX_BAUD_MAX);
	localparam logic [13:0] DIV_MAX = 14'(CLK_HZ / BAUD_MIN);
	localparam logic [2:0] SWITCH_CYC = 3'h4;
	localparam logic [31:0] ODO_MAX_SCALE = 32'h00418937; // 4294967 pulses per metre
	localparam logic [2:0] FIX_3D = 3'h2;
	localparam logic [2:0] NMEA_HDR_LEN = 3'h5;
	localparam logic [7:0] CH_DOLLAR = 8'h24;
	localparam logic [7:0] CH_STAR = 8'h2a;
	localparam logic [3:0] UART_LAST_BIT = 4'h9;

	function automatic logic is_rx_fn(input pin_fn_t f);
		is_rx_fn = (f == FN_NMEA_IN) || (f == FN_POSLOG_IN) || (f == FN_POSMSG_IN)
			|| (f == FN_PKT_IN);
	endfunction

	function automatic logic fn_legal(input logic [1:0] pin, input pin_fn_t f);
		case (f)
			FN_OFF: fn_legal = 1'b1;
			FN_PPS_OUT, FN_FIX_OUT: fn_legal = (pin != PIN_AUX_RX);
			FN_NMEA_OUT: fn_legal = (pin == PIN_GPIO1) || (pin == PIN_AUX_TX);
			FN_ODO_IN, FN_ZVEL_IN, FN_PITOT_IN: fn_legal = (pin != PIN_AUX_TX);
			default: fn_legal = is_rx_fn(f) && ((pin == PIN_GPIO2) || (pin == PIN_AUX_RX));
		endcase
	endfunction
endpackage
